// ---- core/clock_doubler_and_protect_ctrl.sv ----
// Purpose: Clock doubler control, lock-up status, clock select and key protect.
// Assumes: Single-cycle strobes from a bus master on ref_clk_in.
// Notes: Software ordering constraints are not enforced in hardware.
// Function
// [RULE1] Slow oscillator enabled out of reset.
// [RULE2] Standby turns halt select 11 into partial_idle_halt.
// [RULE3] Drive select 0 means partial_idle_halt, 1 means stop.
// [RULE4] Doubler control only written in fast mode.
// [RULE5] Stop doubler in two writes: C0H, 00H.
// [RULE6] Stop doubler before stopping fast oscillator.
// [RULE7] Write 0BH to tuning for 4-9 MHz.
// [RULE8] 5AH then A5H to keys toggles protect.
// [RULE9] A5H then 5AH to keys toggles protect.
// [RULE10] Set drive strength bits before oscillator restart.
// [RULE11] Run select 00 stop, 01 osc, 10 doubler.
// [RULE12] Lock-up flag reads 1 while counting.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module clock_doubler_and_protect_ctrl #(
	parameter int LOCKUP_LONG = clk_dbl_pkg::LOCKUP_LONG_CYCLES,
	parameter int LOCKUP_SHORT = clk_dbl_pkg::LOCKUP_SHORT_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [clk_dbl_pkg::ADDR_W-1:0] addr_in,
	input wire logic [clk_dbl_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [clk_dbl_pkg::DATA_W-1:0] rdata_out,
	input wire logic hw_standby_in,
	output logic fast_osc_en_out,
	output logic slow_osc_en_out,
	output logic sys_clk_slow_out,
	output logic [2:0] clock_gear_out,
	output logic [1:0] halt_mode_out,
	output logic pin_hold_out,
	output logic protect_on_out,
	output logic fast_osc_drive_strength_out,
	output logic slow_osc_drive_strength_out,
	output logic clock_doubler_en_out,
	output logic doubler_clk_sel_out,
	output logic lockup_status_flag_out,
	output logic [7:0] doubler_tuning_out
);

	// Stored registers.
	logic [7:0] osc_ctrl;
	logic [7:0] sysclk_ctrl;
	logic [7:0] standby_ctrl;
	logic [6:0] noise_bits;
	logic protect;
	logic [1:0] doubler_run_select;
	logic lockup_time_select;
	logic [7:0] doubler_tuning;
	clk_dbl_pkg::key_state_t key_state;
	clk_dbl_pkg::key_state_t next_key_state;

	// Standby pin synchroniser.
	logic standby_meta;
	logic standby_sync;

	// Address decode.
	logic hit_osc;
	logic hit_sysclk;
	logic hit_standby;
	logic hit_noise;
	logic hit_key1;
	logic hit_key2;
	logic hit_dctl;
	logic hit_dtune;

	// Doubler lock-up control, protect toggle and halt mode.
	logic lockup_start;
	logic lockup_cancel;
	logic lockup_busy;
	logic protect_toggle;
	logic [1:0] halt_raw;
	logic [1:0] halt_effective;

	assign hit_osc = (addr_in == clk_dbl_pkg::A_OSC_CTRL);
	assign hit_sysclk = (addr_in == clk_dbl_pkg::A_SYSCLK_CTRL);
	assign hit_standby = (addr_in == clk_dbl_pkg::A_STANDBY_CTRL);
	assign hit_noise = (addr_in == clk_dbl_pkg::A_NOISE_CTRL0);
	assign hit_key1 = (addr_in == clk_dbl_pkg::A_KEY_FIRST);
	assign hit_key2 = (addr_in == clk_dbl_pkg::A_KEY_SECOND);
	assign hit_dctl = (addr_in == clk_dbl_pkg::A_DBL_CTRL);
	assign hit_dtune = (addr_in == clk_dbl_pkg::A_DBL_TUNING);

	// The standby pin is asynchronous, so it passes two flops before use.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			standby_meta <= 1'b0;
			standby_sync <= 1'b0;
		end else begin
			standby_meta <= hw_standby_in;
			standby_sync <= standby_meta;
		end
	end

	// Oscillator control; both oscillators run after reset.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			osc_ctrl <= clk_dbl_pkg::RST_OSC_CTRL; // see [RULE1]
		end else if (wr_in && hit_osc) begin
			osc_ctrl <= wdata_in;
		end
	end

	// System clock select and gear.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sysclk_ctrl <= clk_dbl_pkg::RST_SYSCLK_CTRL;
		end else if (wr_in && hit_sysclk) begin
			sysclk_ctrl <= {4'h0, wdata_in[3:0]};
		end
	end

	// Halt mode, warm-up time and pin state control; bit 6 is unused.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			standby_ctrl <= clk_dbl_pkg::RST_STANDBY_CTRL;
		end else if (wr_in && hit_standby) begin
			standby_ctrl <= {wdata_in[7], 1'b0, wdata_in[5:0]};
		end
	end

	// Noise reduction bits below the protect flag are plain storage.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			noise_bits <= clk_dbl_pkg::RST_NOISE_CTRL0;
		end else if (wr_in && hit_noise) begin
			noise_bits <= wdata_in[6:0];
		end
	end

	// Key sequence tracker. The two key bytes must be consecutive writes:
	// any other write in between breaks the sequence, which keeps a stray
	// store from completing half a key left over from earlier code.
	always_comb begin
		next_key_state = key_state;
		protect_toggle = 1'b0;
		if (wr_in) begin
			next_key_state = clk_dbl_pkg::KEY_IDLE;
			case (key_state)
				clk_dbl_pkg::KEY_GOT_5A: begin
					if (hit_key2 && wdata_in == clk_dbl_pkg::KEY_A5) begin
						protect_toggle = 1'b1; // see [RULE8]
					end
				end
				clk_dbl_pkg::KEY_GOT_A5: begin
					if (hit_key2 && wdata_in == clk_dbl_pkg::KEY_5A) begin
						protect_toggle = 1'b1; // see [RULE9]
					end
				end
				default: begin
					protect_toggle = 1'b0;
				end
			endcase
			// A first-key write of 5AH or A5H always opens a new sequence.
			if (hit_key1 && wdata_in == clk_dbl_pkg::KEY_5A) begin
				next_key_state = clk_dbl_pkg::KEY_GOT_5A; // see [RULE8]
			end else if (hit_key1 && wdata_in == clk_dbl_pkg::KEY_A5) begin
				next_key_state = clk_dbl_pkg::KEY_GOT_A5; // see [RULE9]
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			key_state <= clk_dbl_pkg::KEY_IDLE;
		end else begin
			key_state <= next_key_state;
		end
	end

	// Protect flag is read-only and changes only on a completed key.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			protect <= 1'b0;
		end else if (protect_toggle) begin
			protect <= ~protect; // see [RULE8] [RULE9]
		end
	end

	// Doubler control. Ordering against slow mode and oscillator stop is
	// left to software; hardware accepts every write as it comes.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			doubler_run_select <= clk_dbl_pkg::RST_RUN_SELECT;
			lockup_time_select <= clk_dbl_pkg::RST_LOCKUP_TIME;
		end else if (wr_in && hit_dctl) begin
			doubler_run_select <= wdata_in[clk_dbl_pkg::DC_RUN_HI:clk_dbl_pkg::DC_RUN_LO];
			lockup_time_select <= wdata_in[clk_dbl_pkg::DC_LOCK_TIME];
		end
	end

	// Tuning register is plain storage driven to the analogue doubler.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			doubler_tuning <= clk_dbl_pkg::RST_DBL_TUNING;
		end else if (wr_in && hit_dtune) begin
			doubler_tuning <= wdata_in; // see [RULE7]
		end
	end

	// Lock-up starts when the doubler goes from stopped to running and is
	// dropped when software stops it again.
	assign lockup_start = wr_in && hit_dctl
		&& (doubler_run_select == clk_dbl_pkg::RUN_STOPPED)
		&& (wdata_in[clk_dbl_pkg::DC_RUN_HI:clk_dbl_pkg::DC_RUN_LO] != clk_dbl_pkg::RUN_STOPPED);
	assign lockup_cancel = wr_in && hit_dctl
		&& (wdata_in[clk_dbl_pkg::DC_RUN_HI:clk_dbl_pkg::DC_RUN_LO] == clk_dbl_pkg::RUN_STOPPED);

	// Lock-up time bit: 0 selects the long count, 1 the short one. It is taken from the
	// starting write itself, since the stored bit only updates on that same edge.
	lockup_timer #(
		.LONG_CYCLES(LOCKUP_LONG),
		.SHORT_CYCLES(LOCKUP_SHORT)
	) u_lockup (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.start_in(lockup_start),
		.cancel_in(lockup_cancel),
		.short_sel_in(wdata_in[clk_dbl_pkg::DC_LOCK_TIME]),
		.busy_out(lockup_busy)
	);

	// Effective halt mode: in standby the idle2 code is read as partial_idle_halt.
	assign halt_raw = standby_ctrl[clk_dbl_pkg::STBY_HALT_HI:clk_dbl_pkg::STBY_HALT_LO];
	always_comb begin
		if (standby_sync && halt_raw == clk_dbl_pkg::HALT_IDLE2) begin
			halt_effective = clk_dbl_pkg::HALT_PARTIAL_IDLE_HALT; // see [RULE2]
		end else begin
			halt_effective = halt_raw;
		end
	end

	// Register read mux, registered so data stand in the following cycle.
	// Key registers are write-only and unmapped addresses read as zero.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			if (hit_osc) begin
				rdata_out <= osc_ctrl;
			end else if (hit_sysclk) begin
				rdata_out <= sysclk_ctrl;
			end else if (hit_standby) begin
				rdata_out <= standby_ctrl;
			end else if (hit_noise) begin
				rdata_out <= {protect, noise_bits};
			end else if (hit_dctl) begin
				rdata_out <= {doubler_run_select, lockup_busy, lockup_time_select, 4'h0}; // see [RULE12]
			end else if (hit_dtune) begin
				rdata_out <= doubler_tuning;
			end else begin
				rdata_out <= 8'h00;
			end
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// Control outputs, all taken straight from flops or simple decodes.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fast_osc_en_out <= 1'b1;
			slow_osc_en_out <= 1'b1; // see [RULE1]
			sys_clk_slow_out <= 1'b0;
			clock_gear_out <= 3'h4;
			halt_mode_out <= clk_dbl_pkg::HALT_IDLE2;
			pin_hold_out <= 1'b0;
			protect_on_out <= 1'b0;
			fast_osc_drive_strength_out <= 1'b1;
			slow_osc_drive_strength_out <= 1'b1;
			clock_doubler_en_out <= 1'b0;
			doubler_clk_sel_out <= 1'b0;
			lockup_status_flag_out <= 1'b0;
			doubler_tuning_out <= clk_dbl_pkg::RST_DBL_TUNING;
		end else begin
			fast_osc_en_out <= osc_ctrl[clk_dbl_pkg::OSC_FAST_EN];
			slow_osc_en_out <= osc_ctrl[clk_dbl_pkg::OSC_SLOW_EN]; // see [RULE1]
			sys_clk_slow_out <= sysclk_ctrl[clk_dbl_pkg::SYSCLK_SLOW];
			clock_gear_out <= sysclk_ctrl[2:0];
			halt_mode_out <= halt_effective; // see [RULE2]
			// Pin hold applies only in the halt mode the drive select names.
			pin_hold_out <= standby_ctrl[clk_dbl_pkg::STBY_DRV_EN]
				&& (halt_effective == (standby_ctrl[clk_dbl_pkg::STBY_DRV_SEL]
				? clk_dbl_pkg::HALT_STOP : clk_dbl_pkg::HALT_PARTIAL_IDLE_HALT)); // see [RULE3]
			protect_on_out <= protect;
			fast_osc_drive_strength_out <= noise_bits[clk_dbl_pkg::NR_FAST_DRV];
			slow_osc_drive_strength_out <= noise_bits[clk_dbl_pkg::NR_SLOW_DRV];
			clock_doubler_en_out <= (doubler_run_select != clk_dbl_pkg::RUN_STOPPED); // see [RULE11]
			// Hand over to the doubler clock only once lock-up is over, so an
			// early switch never feeds the core an unsettled clock.
			doubler_clk_sel_out <= (doubler_run_select == clk_dbl_pkg::RUN_DBL_CLK)
				&& !lockup_busy; // see [RULE11]
			lockup_status_flag_out <= lockup_busy; // see [RULE12]
			doubler_tuning_out <= doubler_tuning;
		end
	end

endmodule
`default_nettype wire

// ---- core/clk_dbl_pkg.sv ----
// Purpose: Shared constants for the clock doubler and protect controller.
// Assumes: Register indices are word numbers as printed; bus byte address is four times the index.
// Notes: All offsets, named field positions, stored-register reset values and lock-up counts live here.
package clk_dbl_pkg;

	// Register bus widths.
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;

	// Register indices as printed, and their bus byte addresses.
	localparam int IDX_OSC_CTRL = 'h00e0;
	localparam int IDX_SYSCLK_CTRL = 'h00e1;
	localparam int IDX_STANDBY_CTRL = 'h00e2;
	localparam int IDX_NOISE_CTRL0 = 'h00e3;
	localparam int IDX_KEY_FIRST = 'h00e4;
	localparam int IDX_KEY_SECOND = 'h00e5;
	localparam int IDX_DBL_CTRL = 'h00e8;
	localparam int IDX_DBL_TUNING = 'h00e9;
	localparam logic [ADDR_W-1:0] A_OSC_CTRL = ADDR_W'(IDX_OSC_CTRL * 4);
	localparam logic [ADDR_W-1:0] A_SYSCLK_CTRL = ADDR_W'(IDX_SYSCLK_CTRL * 4);
	localparam logic [ADDR_W-1:0] A_STANDBY_CTRL = ADDR_W'(IDX_STANDBY_CTRL * 4);
	localparam logic [ADDR_W-1:0] A_NOISE_CTRL0 = ADDR_W'(IDX_NOISE_CTRL0 * 4);
	localparam logic [ADDR_W-1:0] A_KEY_FIRST = ADDR_W'(IDX_KEY_FIRST * 4);
	localparam logic [ADDR_W-1:0] A_KEY_SECOND = ADDR_W'(IDX_KEY_SECOND * 4);
	localparam logic [ADDR_W-1:0] A_DBL_CTRL = ADDR_W'(IDX_DBL_CTRL * 4);
	localparam logic [ADDR_W-1:0] A_DBL_TUNING = ADDR_W'(IDX_DBL_TUNING * 4);

	// Reset values of the stored registers.
	localparam logic [7:0] RST_OSC_CTRL = 8'he0;
	localparam logic [7:0] RST_SYSCLK_CTRL = 8'h04;
	localparam logic [7:0] RST_STANDBY_CTRL = 8'h2c;
	localparam logic [6:0] RST_NOISE_CTRL0 = 7'h03;
	localparam logic [1:0] RST_RUN_SELECT = 2'h0;
	localparam logic RST_LOCKUP_TIME = 1'b0;
	localparam logic [7:0] RST_DBL_TUNING = 8'h13;

	// Field positions.
	localparam int OSC_FAST_EN = 7;
	localparam int OSC_SLOW_EN = 6;
	localparam int SYSCLK_SLOW = 3;
	localparam int STBY_HALT_HI = 3;
	localparam int STBY_HALT_LO = 2;
	localparam int STBY_DRV_SEL = 1;
	localparam int STBY_DRV_EN = 0;
	localparam int NR_PROTECT = 7;
	localparam int NR_FAST_DRV = 1;
	localparam int NR_SLOW_DRV = 0;
	localparam int DC_RUN_HI = 7;
	localparam int DC_RUN_LO = 6;
	localparam int DC_LOCK_FLAG = 5;
	localparam int DC_LOCK_TIME = 4;

	// Halt mode encodings.
	localparam logic [1:0] HALT_STOP = 2'h1;
	localparam logic [1:0] HALT_PARTIAL_IDLE_HALT = 2'h2;
	localparam logic [1:0] HALT_IDLE2 = 2'h3;

	// Doubler run select encodings.
	localparam logic [1:0] RUN_STOPPED = 2'h0;
	localparam logic [1:0] RUN_OSC_CLK = 2'h1;
	localparam logic [1:0] RUN_DBL_CLK = 2'h2;

	// Key bytes.
	localparam logic [7:0] KEY_5A = 8'h5a;
	localparam logic [7:0] KEY_A5 = 8'ha5;

	// Lock-up times in input clock cycles: 2^12 and 2^10.
	localparam int LOCKUP_LONG_CYCLES = 4096;
	localparam int LOCKUP_SHORT_CYCLES = 1024;

	// One-hot key sequence states.
	typedef enum logic [2:0] {
		KEY_IDLE = 3'b001,
		KEY_GOT_5A = 3'b010,
		KEY_GOT_A5 = 3'b100
	} key_state_t;

endpackage

// ---- core/lockup_timer.sv ----
// Purpose: Counts the doubler lock-up time after a start.
// Assumes: The reference clock stands in for the oscillator clock.
// Notes: A new start restarts the count; a cancel ends it at once.
`timescale 1ns/1ps
`default_nettype none
module lockup_timer #(
	parameter int LONG_CYCLES = 4096,
	parameter int SHORT_CYCLES = 1024
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic cancel_in,
	input wire logic short_sel_in,
	output logic busy_out
);
	localparam int CNT_W = $clog2(LONG_CYCLES + 1);

	logic [CNT_W-1:0] remaining;

	// Load on start, count down to zero; busy while non-zero.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			remaining <= '0;
		end else if (cancel_in) begin
			remaining <= '0;
		end else if (start_in) begin
			remaining <= short_sel_in ? CNT_W'(SHORT_CYCLES) : CNT_W'(LONG_CYCLES);
		end else if (remaining != '0) begin
			remaining <= remaining - CNT_W'(1);
		end
	end

	assign busy_out = (remaining != '0);
endmodule
`default_nettype wire

// ---- testbench/clk_dbl_asserts.sv ----
// Purpose: Port-level checks for the clock doubler and protect controller.
// Assumes: One clock domain; outputs lag a register write by two edges.
// Notes: Lock-up lengths come in as parameters so short test counts work.
`timescale 1ns/1ps
`default_nettype none
module clk_dbl_asserts #(
	parameter int LOCKUP_LONG = 16,
	parameter int LOCKUP_SHORT = 4
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [clk_dbl_pkg::ADDR_W-1:0] addr_in,
	input wire logic [clk_dbl_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic hw_standby_in,
	input wire logic slow_osc_en_out,
	input wire logic [1:0] halt_mode_out,
	input wire logic pin_hold_out,
	input wire logic protect_on_out,
	input wire logic clock_doubler_en_out,
	input wire logic doubler_clk_sel_out,
	input wire logic lockup_status_flag_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	logic [15:0] hi_cnt;
	logic wr_dbl;
	assign wr_dbl = wr_in && addr_in == clk_dbl_pkg::A_DBL_CTRL;
	// Counts flag-high cycles, so a lock-up of the wrong length shows at its fall.
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hi_cnt <= 16'h0000;
		end else begin
			hi_cnt <= lockup_status_flag_out ? hi_cnt + 16'h0001 : 16'h0000;
		end
	end
	sequence s_key(logic [7:0] b1, logic [7:0] b2);
		(wr_in && addr_in == clk_dbl_pkg::A_KEY_FIRST && wdata_in == b1) ##1
		(wr_in && addr_in == clk_dbl_pkg::A_KEY_SECOND && wdata_in == b2);
	endsequence
	property p_slow_osc;
		$rose(rstn_in) |-> slow_osc_en_out;
	endproperty
	a_slow_osc: assert property (p_slow_osc) else $error("slow osc off after reset");
	property p_standby;
		hw_standby_in [*6] |-> halt_mode_out != 2'b11;
	endproperty
	a_standby: assert property (p_standby) else $error("halt 11 kept in standby");
	property p_pin_hold;
		pin_hold_out |-> halt_mode_out == clk_dbl_pkg::HALT_STOP ||
			halt_mode_out == clk_dbl_pkg::HALT_PARTIAL_IDLE_HALT;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin hold in bad mode");
	property p_key1;
		s_key(clk_dbl_pkg::KEY_5A, clk_dbl_pkg::KEY_A5) |->
			##2 protect_on_out != $past(protect_on_out, 2);
	endproperty
	a_key1: assert property (p_key1) else $error("first key did not toggle");
	property p_key2;
		s_key(clk_dbl_pkg::KEY_A5, clk_dbl_pkg::KEY_5A) |->
			##2 protect_on_out != $past(protect_on_out, 2);
	endproperty
	a_key2: assert property (p_key2) else $error("second key did not toggle");
	property p_protect_cause;
		$changed(protect_on_out) |-> $past(wr_in, 2) &&
			$past(addr_in, 2) == clk_dbl_pkg::A_KEY_SECOND;
	endproperty
	a_protect_cause: assert property (p_protect_cause) else $error("protect moved alone");
	property p_run_stop;
		wr_dbl && wdata_in[7:6] == clk_dbl_pkg::RUN_STOPPED |->
			##2 !clock_doubler_en_out && !doubler_clk_sel_out;
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("doubler not stopped");
	property p_run_osc;
		wr_dbl && wdata_in[7:6] == clk_dbl_pkg::RUN_OSC_CLK |->
			##2 clock_doubler_en_out && !doubler_clk_sel_out;
	endproperty
	a_run_osc: assert property (p_run_osc) else $error("run with osc clock wrong");
	property p_lock_start;
		wr_dbl && wdata_in[7:6] != clk_dbl_pkg::RUN_STOPPED && !clock_doubler_en_out &&
			!$past(wr_dbl) |-> ##2 lockup_status_flag_out;
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("lock-up did not start");
	property p_lock_len;
		$fell(lockup_status_flag_out) |-> hi_cnt == LOCKUP_LONG || hi_cnt == LOCKUP_SHORT;
	endproperty
	a_lock_len: assert property (p_lock_len) else $error("lock-up length wrong");
	c_key: cover property (s_key(clk_dbl_pkg::KEY_5A, clk_dbl_pkg::KEY_A5));
	c_lock: cover property ($fell(lockup_status_flag_out));
	c_hold: cover property (pin_hold_out);
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the clock doubler and protect controller.
// Assumes: Bus signals change by non-blocking assignment just after a rising edge.
// Notes: Lock-up counts are shortened so each start ends within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int LONG_N = 16;
	localparam int SHORT_N = 4;
	logic ref_clk_in, rstn_in, wr_in, rd_in, hw_standby_in;
	logic [clk_dbl_pkg::ADDR_W-1:0] addr_in;
	logic [7:0] wdata_in, rdata_out, tuning;
	logic fast_en, slow_en, sys_slow, hold, prot, fast_drv, slow_drv, dbl_en, dbl_sel, flag;
	logic [2:0] gear;
	logic [1:0] halt;
	int failures, check_count;
	clock_doubler_and_protect_ctrl #(.LOCKUP_LONG(LONG_N), .LOCKUP_SHORT(SHORT_N)) uut (
		.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .hw_standby_in(hw_standby_in),
		.fast_osc_en_out(fast_en), .slow_osc_en_out(slow_en), .sys_clk_slow_out(sys_slow),
		.clock_gear_out(gear), .halt_mode_out(halt), .pin_hold_out(hold),
		.protect_on_out(prot), .fast_osc_drive_strength_out(fast_drv),
		.slow_osc_drive_strength_out(slow_drv), .clock_doubler_en_out(dbl_en),
		.doubler_clk_sel_out(dbl_sel), .lockup_status_flag_out(flag),
		.doubler_tuning_out(tuning));
	// Free-running 40 MHz clock.
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// The write task leaves the strobe up, so writes can run back to back.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		wr_in <= 1'b1;
		rd_in <= 1'b0;
		addr_in <= a;
		wdata_in <= d;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		@(negedge ref_clk_in);
		chk("read data", exp, rdata_out);
	endtask
	// Drops strobes and waits until registered outputs have caught up.
	task automatic pause;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask
	task automatic t_reset;
		logic [9:0] a [9];
		logic [7:0] e [9];
		a = '{clk_dbl_pkg::A_OSC_CTRL, clk_dbl_pkg::A_SYSCLK_CTRL, clk_dbl_pkg::A_STANDBY_CTRL,
			clk_dbl_pkg::A_NOISE_CTRL0, clk_dbl_pkg::A_KEY_FIRST, clk_dbl_pkg::A_KEY_SECOND,
			clk_dbl_pkg::A_DBL_CTRL, clk_dbl_pkg::A_DBL_TUNING, 10'h3fc};
		e = '{8'he0, 8'h04, 8'h2c, 8'h03, 8'h00, 8'h00, 8'h00, 8'h13, 8'h00};
		@(negedge ref_clk_in);
		chk("osc enables", 8'h03, {6'h00, fast_en, slow_en});
		chk("gear after reset", 8'h04, {4'h0, sys_slow, gear});
		for (int i = 0; i < 9; i++) begin
			rd(a[i], e[i]);
		end
	endtask
	// Drive strengths go weak first, so the later restore to normal is a real change.
	task automatic t_regs;
		wr(clk_dbl_pkg::A_DBL_TUNING, 8'h0b);
		wr(clk_dbl_pkg::A_NOISE_CTRL0, 8'h80);
		wr(clk_dbl_pkg::A_SYSCLK_CTRL, 8'hf9);
		pause;
		chk("tuning out", 8'h0b, tuning);
		chk("weak drive", 8'h00, {6'h00, fast_drv, slow_drv});
		chk("slow and gear", 8'h09, {4'h0, sys_slow, gear});
		rd(clk_dbl_pkg::A_SYSCLK_CTRL, 8'h09);
		wr(clk_dbl_pkg::A_SYSCLK_CTRL, 8'h04);
		wr(clk_dbl_pkg::A_NOISE_CTRL0, 8'h83);
		pause;
		chk("drive strengths", 8'h03, {6'h00, fast_drv, slow_drv});
		chk("fast mode gear", 8'h04, {4'h0, sys_slow, gear});
		rd(clk_dbl_pkg::A_NOISE_CTRL0, 8'h03);
	endtask
	task automatic t_keys;
		wr(clk_dbl_pkg::A_KEY_FIRST, 8'h5a);
		wr(clk_dbl_pkg::A_KEY_SECOND, 8'ha5);
		pause;
		chk("protect on", 8'h01, {7'h00, prot});
		rd(clk_dbl_pkg::A_NOISE_CTRL0, 8'h83);
		wr(clk_dbl_pkg::A_KEY_FIRST, 8'ha5);
		wr(clk_dbl_pkg::A_KEY_SECOND, 8'h5a);
		pause;
		chk("protect off", 8'h00, {7'h00, prot});
		wr(clk_dbl_pkg::A_KEY_FIRST, 8'h5a);
		wr(clk_dbl_pkg::A_DBL_TUNING, 8'h0b);
		wr(clk_dbl_pkg::A_KEY_SECOND, 8'ha5);
		pause;
		chk("aborted key", 8'h00, {7'h00, prot});
	endtask
	// Starts the doubler from stopped and measures how long the flag stays up.
	task automatic lock(input logic [7:0] d, input int n);
		int cnt;
		int i;
		cnt = 0;
		i = 0;
		wr(clk_dbl_pkg::A_DBL_CTRL, d);
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
		while (i < 100 && !(cnt > 0 && flag === 1'b0)) begin
			@(negedge ref_clk_in);
			cnt += (flag === 1'b1) ? 1 : 0;
			i++;
		end
		if (i == 100) begin
			failures++;
			finish_test;
		end
		chk("lock-up cycles", 8'(n), 8'(cnt));
	endtask
	// The first stop also sets the read-only flag bit, which must read back as zero.
	task automatic t_doubler;
		lock(8'h40, LONG_N);
		chk("run osc en sel", 8'h02, {6'h00, dbl_en, dbl_sel});
		wr(clk_dbl_pkg::A_DBL_CTRL, 8'h20);
		pause;
		chk("stopped en sel", 8'h00, {6'h00, dbl_en, dbl_sel});
		rd(clk_dbl_pkg::A_DBL_CTRL, 8'h00);
		lock(8'h90, SHORT_N);
		@(negedge ref_clk_in);
		chk("run dbl en sel", 8'h03, {6'h00, dbl_en, dbl_sel});
		rd(clk_dbl_pkg::A_DBL_CTRL, 8'h90);
		wr(clk_dbl_pkg::A_DBL_CTRL, 8'hc0);
		pause;
		chk("back to osc", 8'h02, {6'h00, dbl_en, dbl_sel});
		wr(clk_dbl_pkg::A_DBL_CTRL, 8'h00);
		pause;
		chk("doubler off", 8'h00, {6'h00, dbl_en, dbl_sel});
		rd(clk_dbl_pkg::A_DBL_CTRL, 8'h00);
		wr(clk_dbl_pkg::A_OSC_CTRL, 8'h60);
		pause;
		chk("fast osc off", 8'h01, {6'h00, fast_en, slow_en});
	endtask
	task automatic t_halt;
		logic [7:0] v [5];
		logic [2:0] e [5];
		v = '{8'h29, 8'h2b, 8'h27, 8'h25, 8'h2d};
		e = '{3'b101, 3'b100, 3'b011, 3'b010, 3'b110};
		for (int i = 0; i < 5; i++) begin
			wr(clk_dbl_pkg::A_STANDBY_CTRL, v[i]);
			pause;
			chk("halt and hold", {5'h00, e[i]}, {5'h00, halt, hold});
		end
		@(posedge ref_clk_in);
		hw_standby_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk("standby halt", 8'h05, {5'h00, halt, hold});
		@(posedge ref_clk_in);
		hw_standby_in <= 1'b0;
	endtask
	// Hang guard: a run this long means a handshake never finished.
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		failures++;
		finish_test;
	end
	initial begin
		failures = 0;
		check_count = 0;
		rstn_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = '0;
		wdata_in = 8'h00;
		hw_standby_in = 1'b0;
		repeat (6) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		t_reset;
		t_regs;
		t_keys;
		t_doubler;
		t_halt;
		finish_test;
	end
endmodule
bind clock_doubler_and_protect_ctrl clk_dbl_asserts #(.LOCKUP_LONG(LOCKUP_LONG),
	.LOCKUP_SHORT(LOCKUP_SHORT)) chk_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .hw_standby_in(hw_standby_in),
	.slow_osc_en_out(slow_osc_en_out), .halt_mode_out(halt_mode_out),
	.pin_hold_out(pin_hold_out), .protect_on_out(protect_on_out),
	.clock_doubler_en_out(clock_doubler_en_out), .doubler_clk_sel_out(doubler_clk_sel_out),
	.lockup_status_flag_out(lockup_status_flag_out));
`default_nettype wire
